/* design/atr_if_checker.sv */
// Purpose: checks the first and second interface character groups of an
//          answer-to-reset and latches the resulting link parameters
// Assumes: format_char is the first character after atr_start; the
//          receiver pulses atr_done after the last interface character
// Notes:   verdict comes two cycles after atr_done
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// [R01] first supply char: voltage low five, current next
// [R02] card's basic first supply char is 00
// [R03] cold answer needs first supply char 00
// [R04] warm answer: any supply char, treat as 00
// [R05] never drive the programming supply
// [R06] guard char adds that many etus spacing
// [R07] guard FF: 12 etus T0, 11 T1
// [R08] extra guard only between terminal characters
// [R09] absent guard char means guard 00
// [R10] first chain high nibble flags group two
// [R11] first chain consistent, protocol 0 or 1
// [R12] card omits first chain for T0 only
// [R13] mode char: change bit, reserved, implicit bit
// [R14] mode char present means specific mode
// [R15] mode char protocol matches, b5 zero, supported
// [R16] reject any second supply character
// [R17] waiting time 960 D integer, default 10
// [R18] waiting integer 00 rejected, 0A accepted
// [R19] second chain high nibble flags group three
// [R20] second chain protocol 1, or E after 0
// [R21] card sends second chain 31 for T1
// [R22] format char high nibble flags group one
// [R23] one verdict per answer, parameters latched
module atr_if_checker
  import atr_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  input logic atr_start,
  input logic warm_reset,
  input logic char_valid,
  input logic [7:0] char_data,
  input logic atr_done,
  input logic [5:0] d_factor,
  input logic [7:0] addr,
  input logic [31:0] wdata,
  input logic wr_en,
  input logic rd_en,
  output logic [31:0] rdata,
  output logic verdict_valid,
  output logic atr_accept,
  output logic warm_reset_req,
  output logic deactivate_req,
  output logic proto_t1,
  output logic specific_mode,
  output logic [7:0] wait_int,
  output logic [8:0] tx_gap_etu,
  output logic [23:0] wwt_etu,
  output logic vpp_enable
);

  chk_state_t state_q;
  logic warm_q, fmt_seen_q, err_q, load_q, done_q;
  logic [3:0] pend_q;
  logic [1:0] grp_q;
  logic tb1_seen_q, tc1_seen_q, ta2_seen_q, tb2_seen_q, tc2_seen_q;
  logic [7:0] tb1_q, gt_n_q, ta2_q, tc2_q, td2_q;
  logic [3:0] td1_proto_q;
  logic [1:0] ctrl_q;
  logic [31:0] rdata_q, rd_mux;
  logic verdict_q, accept_q, warm_req_q, deact_q;
  logic t1_q, specific_q, change_q, vpp_q;
  logic [7:0] wait_int_q;
  logic [1:0] cur_idx;
  logic [3:0] slot;
  logic char_bad, take_char, take_iface, start_ok, go_calc, final_bad;

  atr_param_if prm();

  // position of the next expected character inside the current group
  function automatic logic [1:0] low_idx(input logic [3:0] m);
    if (m[0]) low_idx = 2'h0;
    else if (m[1]) low_idx = 2'h1;
    else if (m[2]) low_idx = 2'h2;
    else low_idx = 2'h3;
  endfunction

  // slot decode and handshake terms
  assign cur_idx = low_idx(pend_q);
  assign slot = {grp_q, cur_idx};
  assign start_ok = atr_start && (state_q != ST_CALC);
  assign take_char = char_valid && (state_q == ST_CHARS) && !atr_start;
  assign take_iface = take_char && fmt_seen_q && (pend_q != 4'h0);
  assign go_calc = (state_q == ST_CHARS) && !atr_start && atr_done;
  assign final_bad = err_q || (pend_q != 4'h0) || !fmt_seen_q ||
                     (!warm_q && !tb1_seen_q); // R03

  field_check u_check (
    .slot(slot),
    .ch(char_data),
    .warm(warm_q),
    .first_proto(td1_proto_q),
    .wi_any_ok(ctrl_q[CTRL_WI_ANY_BIT]),
    .ta2_ok(ctrl_q[CTRL_TA2_OK_BIT]),
    .bad(char_bad)
  );

  // parameters handed to the timing calculator
  assign prm.load = load_q;
  assign prm.t1 = (td1_proto_q == PROTO_T1);
  assign prm.guard_n = gt_n_q;
  assign prm.wi = tc2_q;
  assign prm.d_factor = d_factor;

  wait_guard_calc u_calc (
    .mclk(mclk),
    .rst_n(rst_n),
    .p(prm.calc)
  );

  // checker phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (atr_start) state_q <= ST_CHARS;
        ST_CHARS: if (go_calc) state_q <= ST_CALC;
        ST_CALC: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // reset kind of the answer under test
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 1'b0;
    end else if (start_ok) begin
      warm_q <= warm_reset;
    end
  end

  // presence map walk through the chained groups
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_seen_q <= 1'b0;
      pend_q <= 4'h0;
      grp_q <= 2'h0;
    end else if (start_ok) begin
      fmt_seen_q <= 1'b0;
      pend_q <= 4'h0;
      grp_q <= 2'h0;
    end else if (take_char && !fmt_seen_q) begin
      fmt_seen_q <= 1'b1;
      pend_q <= char_data[7:4]; // R22
    end else if (take_iface) begin
      if (cur_idx == 2'h3) begin
        pend_q <= char_data[7:4]; // R10 R19
        grp_q <= (grp_q == 2'h3) ? grp_q : grp_q + 2'h1;
      end else begin
        pend_q <= pend_q & ~(4'h1 << cur_idx);
      end
    end
  end

  // sticky error: bad value or character beyond the announced set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 1'b0;
    end else if (start_ok) begin
      err_q <= 1'b0;
    end else if (take_char && fmt_seen_q &&
                 ((pend_q == 4'h0) || char_bad)) begin
      err_q <= 1'b1; // R11 R22
    end
  end

  // captured characters, with defaults for absent ones
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tb1_seen_q <= 1'b0;
      tb1_q <= PS1_NONE;
      tc1_seen_q <= 1'b0;
      gt_n_q <= GT_DEFAULT;
      td1_proto_q <= PROTO_T0;
      ta2_seen_q <= 1'b0;
      ta2_q <= 8'h00;
      tb2_seen_q <= 1'b0;
      tc2_seen_q <= 1'b0;
      tc2_q <= WI_DEFAULT;
      td2_q <= 8'h00;
    end else if (start_ok) begin
      tb1_seen_q <= 1'b0;
      tb1_q <= PS1_NONE;
      tc1_seen_q <= 1'b0;
      gt_n_q <= GT_DEFAULT; // R09
      td1_proto_q <= PROTO_T0; // R12
      ta2_seen_q <= 1'b0;
      ta2_q <= 8'h00;
      tb2_seen_q <= 1'b0;
      tc2_seen_q <= 1'b0;
      tc2_q <= WI_DEFAULT; // R17
      td2_q <= 8'h00;
    end else if (take_iface) begin
      case (slot)
        SLOT_B1: begin
          tb1_seen_q <= 1'b1;
          tb1_q <= warm_q ? PS1_NONE : char_data; // R04
        end
        SLOT_C1: begin
          tc1_seen_q <= 1'b1;
          gt_n_q <= char_data;
        end
        SLOT_D1: td1_proto_q <= char_data[3:0]; // R10
        SLOT_A2: begin
          ta2_seen_q <= 1'b1; // R14
          ta2_q <= char_data; // R13
        end
        SLOT_B2: tb2_seen_q <= 1'b1;
        SLOT_C2: begin
          tc2_seen_q <= 1'b1;
          tc2_q <= char_data;
        end
        SLOT_D2: td2_q <= char_data; // R19
        default: ;
      endcase
    end
  end

  // calculator load pulse, the edge after atr_done
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b0;
    end else begin
      load_q <= go_calc;
    end
  end

  // verdict and follow-up request, one per answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      verdict_q <= 1'b0;
      accept_q <= 1'b0;
      warm_req_q <= 1'b0;
      deact_q <= 1'b0;
      done_q <= 1'b0;
    end else if (state_q == ST_CALC) begin
      verdict_q <= 1'b1; // R23
      accept_q <= !final_bad;
      warm_req_q <= final_bad && !warm_q;
      deact_q <= final_bad && warm_q;
      done_q <= 1'b1;
    end else begin
      verdict_q <= 1'b0;
      warm_req_q <= 1'b0;
      deact_q <= 1'b0;
      if (start_ok) begin
        accept_q <= 1'b0;
        done_q <= 1'b0;
      end
    end
  end

  // parameters latched for the transmission logic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t1_q <= 1'b0;
      specific_q <= 1'b0;
      change_q <= 1'b0;
      wait_int_q <= WI_DEFAULT;
    end else if (state_q == ST_CALC) begin
      t1_q <= (td1_proto_q == PROTO_T1); // R23
      specific_q <= ta2_seen_q; // R14
      change_q <= ta2_seen_q && ta2_q[7]; // R13
      wait_int_q <= tc2_q; // R17
    end
  end

  // programming supply output held off forever
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vpp_q <= 1'b0;
    end else begin
      vpp_q <= 1'b0; // R05
    end
  end

  // software control word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && (addr == ADDR_CTRL)) begin
      ctrl_q <= wdata[1:0];
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      ADDR_CTRL: rd_mux[1:0] = ctrl_q;
      ADDR_STATUS: begin
        rd_mux[ST_DONE_BIT] = done_q;
        rd_mux[ST_ACCEPT_BIT] = accept_q;
        rd_mux[ST_WARM_BIT] = warm_q;
        rd_mux[ST_SPECIFIC_BIT] = specific_q;
        rd_mux[ST_CHANGE_BIT] = change_q;
        rd_mux[ST_T1_BIT] = t1_q;
        rd_mux[ST_BUSY_BIT] = (state_q != ST_IDLE);
        rd_mux[ST_PVOLT_LSB +: 5] = tb1_q[4:0]; // R01
        rd_mux[ST_PCURR_LSB +: 2] = tb1_q[6:5]; // R01
      end
      ADDR_GUARD: begin
        rd_mux[8:0] = prm.gap_etu; // R08
        rd_mux[23:16] = gt_n_q;
      end
      ADDR_WAIT: rd_mux[7:0] = wait_int_q;
      ADDR_WWT: rd_mux[23:0] = prm.wwt_etu;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  // outputs straight from flops
  assign rdata = rdata_q;
  assign verdict_valid = verdict_q;
  assign atr_accept = accept_q;
  assign warm_reset_req = warm_req_q;
  assign deactivate_req = deact_q;
  assign proto_t1 = t1_q;
  assign specific_mode = specific_q;
  assign wait_int = wait_int_q;
  assign tx_gap_etu = prm.gap_etu; // R08
  assign wwt_etu = prm.wwt_etu;
  assign vpp_enable = vpp_q;

  // checks on the verdict and the latched parameters
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_cold_ps_value: assert property (verdict_q && !warm_q && tb1_seen_q && // R03
    (tb1_q != PS1_NONE) |-> !accept_q) else $error("cold supply char");
  a_cold_ps_absent: assert property (verdict_q && !warm_q && // R03
    !tb1_seen_q |-> !accept_q) else $error("cold supply char missing");
  a_warm_ps_zero: assert property (verdict_q && warm_q |-> // R04
    tb1_q == PS1_NONE) else $error("warm supply not treated as 00");
  a_no_vpp: assert property (!vpp_enable) // R05
    else $error("programming supply driven");
  a_gap_add: assert property (verdict_q && (gt_n_q != GT_SPECIAL) |-> // R06
    tx_gap_etu == GAP_BASE + {1'b0, gt_n_q}) else $error("guard gap");
  a_gap_special: assert property (verdict_q && (gt_n_q == GT_SPECIAL) |-> // R07
    tx_gap_etu == ((td1_proto_q == PROTO_T1) ? GAP_T1_FF : GAP_T0_FF))
    else $error("special guard gap");
  a_gap_default: assert property (verdict_q && !tc1_seen_q |-> // R09
    tx_gap_etu == GAP_BASE) else $error("absent guard not zero");
  a_proto_range: assert property (verdict_q && (td1_proto_q > PROTO_T1) // R11
    |-> !accept_q) else $error("bad protocol accepted");
  a_extra_char: assert property (take_char && fmt_seen_q && // R22
    (pend_q == 4'h0) |=> err_q) else $error("extra char not flagged");
  a_mode_implicit: assert property (verdict_q && ta2_seen_q && ta2_q[4] // R15
    |-> !accept_q) else $error("implicit mode accepted");
  a_no_supply2: assert property (verdict_q && tb2_seen_q |-> !accept_q) // R16
    else $error("second supply char accepted");
  a_wait_time: assert property (verdict_q |-> wwt_etu == // R17
    WWT_FACTOR * 24'($past(d_factor)) * 24'(tc2_q)) else $error("wwt");
  a_wait_zero: assert property (verdict_q && tc2_seen_q && // R18
    (tc2_q == WI_ZERO) |-> !accept_q) else $error("wait 00 accepted");
  a_chain2_proto: assert property (verdict_q && (td2_q[3:0] != PROTO_T1) // R20
    && ((td2_q[3:0] != PROTO_E) || (td1_proto_q != PROTO_T0))
    && (td2_q != 8'h00) |-> !accept_q) else $error("bad second chain");
  a_one_verdict: assert property (go_calc |-> ##2 verdict_q ##1 // R23
    !verdict_q) else $error("verdict timing");
  a_req_pair: assert property (verdict_q |-> // R23
    accept_q ^ (warm_reset_req | deactivate_req))
    else $error("verdict and request disagree");

  c_cold_accept: cover property (verdict_q && accept_q && !warm_q);
  c_warm_reject: cover property (verdict_q && !accept_q && warm_q);
  c_t1_accept: cover property (verdict_q && accept_q && t1_q);
  c_specific: cover property (verdict_q && accept_q && specific_q);

endmodule

/* design/atr_param_if.sv */
// Purpose: carries latched answer-to-reset parameters to the timing
//          calculator and its results back
// Assumes: single clock domain
// Notes:   load is a one-cycle pulse
`timescale 1ns/1ps
interface atr_param_if;
  logic load;
  logic t1;
  logic [7:0] guard_n;
  logic [7:0] wi;
  logic [5:0] d_factor;
  logic [8:0] gap_etu;
  logic [23:0] wwt_etu;

  modport ctl (output load, t1, guard_n, wi, d_factor,
               input gap_etu, wwt_etu);
  modport calc (input load, t1, guard_n, wi, d_factor,
                output gap_etu, wwt_etu);
endinterface

/* design/atr_pkg.sv */
// Purpose: shared constants and types for the answer-to-reset interface
//          character checker
// Assumes: characters arrive already de-framed, parity checked and in
//          direct convention
// Notes:   register offsets are byte addresses of aligned 32-bit words
package atr_pkg;

  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GUARD = 8'h08;
  localparam logic [7:0] ADDR_WAIT = 8'h0C;
  localparam logic [7:0] ADDR_WWT = 8'h10;

  // control fields
  localparam int CTRL_WI_ANY_BIT = 0;
  localparam int CTRL_TA2_OK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ACCEPT_BIT = 1;
  localparam int ST_WARM_BIT = 2;
  localparam int ST_SPECIFIC_BIT = 3;
  localparam int ST_CHANGE_BIT = 4;
  localparam int ST_T1_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_PVOLT_LSB = 8;
  localparam int ST_PCURR_LSB = 13;

  // character values
  localparam logic [7:0] PS1_NONE = 8'h00;
  localparam logic [7:0] GT_SPECIAL = 8'hFF;
  localparam logic [7:0] GT_DEFAULT = 8'h00;
  localparam logic [7:0] WI_DEFAULT = 8'h0A;
  localparam logic [7:0] WI_ZERO = 8'h00;
  localparam logic [3:0] PROTO_T0 = 4'h0;
  localparam logic [3:0] PROTO_T1 = 4'h1;
  localparam logic [3:0] PROTO_E = 4'hE;

  // character slots: {group - 1, position A/B/C/D}
  localparam logic [3:0] SLOT_B1 = 4'h1;
  localparam logic [3:0] SLOT_C1 = 4'h2;
  localparam logic [3:0] SLOT_D1 = 4'h3;
  localparam logic [3:0] SLOT_A2 = 4'h4;
  localparam logic [3:0] SLOT_B2 = 4'h5;
  localparam logic [3:0] SLOT_C2 = 4'h6;
  localparam logic [3:0] SLOT_D2 = 4'h7;

  // timing counts in etus
  localparam logic [8:0] GAP_BASE = 9'h00C;
  localparam logic [8:0] GAP_T0_FF = 9'h00C;
  localparam logic [8:0] GAP_T1_FF = 9'h00B;
  localparam logic [23:0] WWT_FACTOR = 24'h0003C0;

  typedef enum logic [1:0] {ST_IDLE, ST_CHARS, ST_CALC} chk_state_t;

endpackage

/* design/field_check.sv */
// Purpose: judges one interface character against its slot
// Assumes: slot and first protocol come from the sequencer
// Notes:   purely combinational; bad is high for an unacceptable value
`timescale 1ns/1ps
module field_check
  import atr_pkg::*;
(
  input logic [3:0] slot,
  input logic [7:0] ch,
  input logic warm,
  input logic [3:0] first_proto,
  input logic wi_any_ok,
  input logic ta2_ok,
  output logic bad
);

  // per-slot legality of the received value
  always_comb begin
    bad = 1'b0;
    case (slot)
      SLOT_B1: bad = !warm && (ch != PS1_NONE); // R03 R04
      SLOT_D1: bad = ch[3:0] > PROTO_T1; // R11
      SLOT_A2: bad = (ch[3:0] != first_proto) || ch[4] || !ta2_ok; // R15
      SLOT_B2: bad = 1'b1; // R16
      SLOT_C2: bad = (ch == WI_ZERO) ||
                     ((ch != WI_DEFAULT) && !wi_any_ok); // R18
      SLOT_D2: bad = !((ch[3:0] == PROTO_T1) ||
                       ((ch[3:0] == PROTO_E) &&
                        (first_proto == PROTO_T0))); // R20
      default: bad = 1'b0;
    endcase
  end

endmodule

/* design/wait_guard_calc.sv */
// Purpose: turns guard and waiting integers into etu counts
// Assumes: inputs are stable in the cycle load is high
// Notes:   results change only on load
`timescale 1ns/1ps
module wait_guard_calc
  import atr_pkg::*;
(
  input logic mclk,
  input logic rst_n,
  atr_param_if.calc p
);

  // least start-to-start spacing between two terminal characters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p.gap_etu <= GAP_BASE;
    end else if (p.load) begin
      if (p.guard_n == GT_SPECIAL) begin
        p.gap_etu <= p.t1 ? GAP_T1_FF : GAP_T0_FF; // R07
      end else begin
        p.gap_etu <= GAP_BASE + {1'b0, p.guard_n}; // R06
      end
    end
  end

  // work waiting time, 960 x D x integer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p.wwt_etu <= WWT_FACTOR * 24'(WI_DEFAULT);
    end else if (p.load) begin
      p.wwt_etu <= WWT_FACTOR * 24'(p.d_factor) * 24'(p.wi); // R17
    end
  end

endmodule

/* tb/atr_if_checker_tb.sv */
// Purpose: self-checking bench for the interface character checker
// Assumes: verdict two cycles after the end marker; d_factor held steady
// Notes:   expected values are worked out by hand from the character values
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("FAIL at %0t got %0h exp %0h", $time, (a), (b)); end end
module atr_if_checker_tb
  import atr_pkg::*;
;
  logic mclk, rst_n, atr_start, warm_reset, char_valid, atr_done;
  logic [7:0] char_data, addr, wait_int;
  logic [5:0] d_factor;
  logic [31:0] wdata, rdata;
  logic wr_en, rd_en, verdict_valid, atr_accept, warm_reset_req;
  logic deactivate_req, proto_t1, specific_mode, vpp_enable;
  logic [8:0] tx_gap_etu;
  logic [23:0] wwt_etu;
  int n_errors = 0;
  int comparisons = 0;
  int ntest = 0;
  int slow = 0;

  atr_if_checker DUT (.mclk(mclk), .rst_n(rst_n), .atr_start(atr_start),
    .warm_reset(warm_reset), .char_valid(char_valid),
    .char_data(char_data), .atr_done(atr_done), .d_factor(d_factor),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .verdict_valid(verdict_valid), .atr_accept(atr_accept),
    .warm_reset_req(warm_reset_req), .deactivate_req(deactivate_req),
    .proto_t1(proto_t1), .specific_mode(specific_mode),
    .wait_int(wait_int), .tx_gap_etu(tx_gap_etu), .wwt_etu(wwt_etu),
    .vpp_enable(vpp_enable));

  card_model card (.mclk(mclk), .char_valid(char_valid),
    .char_data(char_data), .atr_done(atr_done));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // one-cycle register read, data checked in the following cycle, zero checked in the cycle after
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, e)
    @(posedge mclk);
    #1;
    `CHK(rdata, 32'h00000000)
  endtask

  // one answer: start, characters, then verdict and link parameters
  task automatic run(input logic w, input int n, input logic [63:0] b,
                     input logic a, input logic [8:0] g);
    @(posedge mclk);
    atr_start <= 1'b1;
    warm_reset <= w;
    @(posedge mclk);
    atr_start <= 1'b0;
    card.answer(n, b, slow);
    @(posedge mclk);
    #1;
    `CHK(verdict_valid, 1'b1)
    `CHK(atr_accept, a)
    `CHK(warm_reset_req, ~a & ~w)
    `CHK(deactivate_req, ~a & w)
    `CHK(vpp_enable, 1'b0)
    if (a) `CHK(tx_gap_etu, g)
    @(posedge mclk);
    #1;
    `CHK(verdict_valid, 1'b0)
    ntest++;
    $display("test %0d done", ntest);
  endtask

  // prints counts and verdict, then ends the run
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    final_report;
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    atr_start = 1'b0;
    warm_reset = 1'b0;
    d_factor = 6'h01;
    addr = 8'h00;
    wdata = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    `CHK(wait_int, WI_DEFAULT)
    `CHK(tx_gap_etu, 9'h00C)
    `CHK(wwt_etu, 24'h002580)
    rd(ADDR_CTRL, 32'h00000000);
    run(1'b0, 3, 64'h600000, 1'b1, 9'h00C);
    `CHK(proto_t1, 1'b0)
    `CHK(specific_mode, 1'b0)
    `CHK(wwt_etu, 24'h002580)
    run(1'b0, 7, 64'hE0000081_31FE45, 1'b1, 9'h00C);
    `CHK(proto_t1, 1'b1)
    run(1'b0, 3, 64'h604500, 1'b0, 9'h000);
    // cold supply char 45 decodes to voltage index 5, current index 2
    rd(ADDR_STATUS, 32'h00004501);
    run(1'b0, 2, 64'h4005, 1'b0, 9'h000);
    run(1'b1, 3, 64'h602505, 1'b1, 9'h011);
    rd(ADDR_STATUS, 32'h00000007);
    rd(ADDR_GUARD, 32'h00050011);
    wr(ADDR_GUARD, 32'hFFFFFFFF);
    rd(ADDR_GUARD, 32'h00050011);
    rd(8'h14, 32'h00000000);
    run(1'b1, 2, 64'h4005, 1'b1, 9'h011);
    run(1'b0, 3, 64'h6000FE, 1'b1, 9'h10A);
    run(1'b0, 3, 64'h6000FF, 1'b1, 9'h00C);
    run(1'b0, 7, 64'hE000FF81_31FE45, 1'b1, 9'h00B);
    run(1'b0, 2, 64'h2000, 1'b1, 9'h00C);
    slow = 3;
    run(1'b0, 3, 64'h600003, 1'b1, 9'h00F);
    slow = 0;
    run(1'b0, 4, 64'hE0000002, 1'b0, 9'h000);
    run(1'b0, 4, 64'hE0000081, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE000001080, 1'b0, 9'h000);
    wr(ADDR_CTRL, 32'h00000002);
    run(1'b0, 5, 64'hE000001080, 1'b1, 9'h00C);
    `CHK(specific_mode, 1'b1)
    rd(ADDR_STATUS, 32'h0000001B);
    run(1'b0, 5, 64'hE000001090, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE000001081, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE000002000, 1'b0, 9'h000);
    run(1'b1, 5, 64'hE000002000, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE00000400A, 1'b1, 9'h00C);
    `CHK(wait_int, 8'h0A)
    run(1'b0, 5, 64'hE000004000, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE000004005, 1'b0, 9'h000);
    wr(ADDR_CTRL, 32'h00000001);
    d_factor <= 6'h04;
    run(1'b0, 5, 64'hE000004005, 1'b1, 9'h00C);
    `CHK(wait_int, 8'h05)
    `CHK(wwt_etu, 24'h004B00)
    rd(ADDR_WWT, 32'h00004B00);
    rd(ADDR_WAIT, 32'h00000005);
    d_factor <= 6'h01;
    run(1'b0, 5, 64'hE00000800E, 1'b1, 9'h00C);
    `CHK(proto_t1, 1'b0)
    run(1'b0, 5, 64'hE000008002, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE00000810E, 1'b0, 9'h000);
    run(1'b0, 5, 64'hE000008011, 1'b0, 9'h000);
    run(1'b0, 6, 64'hE00000812145, 1'b1, 9'h00C);
    final_report;
  end
endmodule

/* tb/card_model.sv */
// Purpose: card side of the answer-to-reset character stream
// Assumes: characters are already de-framed; one character per valid pulse
// Notes:   the caller chooses the characters, so wrong answers are ordered
//          on purpose; between characters the data shows no stale value
`timescale 1ns/1ps
module card_model (
  input logic mclk,
  output logic char_valid,
  output logic [7:0] char_data,
  output logic atr_done
);
  // idle line before the first answer
  initial begin
    char_valid = 1'b0;
    char_data = 8'hA5;
    atr_done = 1'b0;
  end

  // sends n characters, first one in the top used byte, then marks the end
  task automatic answer(input int n, input logic [63:0] b, input int gap);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) begin
      c = b[8*(n-1-i)+:8];
      @(posedge mclk);
      char_valid <= 1'b1;
      char_data <= c;
      // slow card: idle cycles between characters
      if (gap > 0) begin
        @(posedge mclk);
        char_valid <= 1'b0;
        char_data <= ~c;
        repeat (gap - 1) @(posedge mclk);
      end
    end
    // end marker never shares a cycle with a character
    @(posedge mclk);
    char_valid <= 1'b0;
    char_data <= ~c;
    atr_done <= 1'b1;
    @(posedge mclk);
    atr_done <= 1'b0;
  endtask
endmodule
